// ---- dv/cssw_clock_switch_checker.sv ----
// Port checker of the core clock switch.
`timescale 1ns/1ps
// ====
// Checker
module cssw_clock_switch_checker
	import cssw_pkg::*;
#(
	parameter int TRIM_W = 8
) (
	input wire logic sys_clk_i,
	input wire logic srst_i,
	input wire cssw_bus_req_t bus_req_i,
	input wire logic [7:0] bus_rdata_o,
	input wire cssw_cal_t cal_opt_i,
	input wire logic core_clock_o,
	input wire logic fast_rc_osc_en_o,
	input wire logic slow_rc_osc_en_o,
	input wire logic ultra_slow_rc_osc_en_o,
	input wire logic [TRIM_W-1:0] fast_rc_trim_o,
	input wire logic wdt_en_o,
	input wire logic port_a_pin5_input_o,
	input wire logic calibrated_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (srst_i);
	logic wm;
	assign wm = bus_req_i.we && bus_req_i.addr == OFF_CLKMD;
	property p_fast_en; wm |=> fast_rc_osc_en_o == $past(bus_req_i.wdata[CLKMD_FAST_EN_BIT]); endproperty
	a_fast_en: assert property (p_fast_en) else $error("fast enable missed write");
	property p_slow_en; wm |=> slow_rc_osc_en_o == $past(bus_req_i.wdata[CLKMD_SLOW_EN_BIT]); endproperty
	a_slow_en: assert property (p_slow_en) else $error("slow enable missed write");
	property p_rback; wm ##1 (bus_req_i.re && bus_req_i.addr == OFF_CLKMD) |=> bus_rdata_o == $past(bus_req_i.wdata, 2); endproperty
	a_rback: assert property (p_rback) else $error("mode readback wrong");
	property p_ultra; ultra_slow_rc_osc_en_o; endproperty
	a_ultra: assert property (p_ultra) else $error("ultra slow oscillator off");
	property p_boot_cal; $fell(srst_i) && cal_opt_i != CAL_OFF |-> !wdt_en_o && slow_rc_osc_en_o && port_a_pin5_input_o && calibrated_o; endproperty
	a_boot_cal: assert property (p_boot_cal) else $error("calibrated boot state wrong");
	property p_boot_off; $fell(srst_i) && cal_opt_i == CAL_OFF |-> wdt_en_o && slow_rc_osc_en_o && port_a_pin5_input_o && !calibrated_o; endproperty
	a_boot_off: assert property (p_boot_off) else $error("uncalibrated boot state wrong");
	// A runt high pulse would be shorter than any legal divided period.
	property p_runt; $rose(core_clock_o) |-> ##1 core_clock_o [*3]; endproperty
	a_runt: assert property (p_runt) else $error("runt pulse on core clock");
	property p_trim; bus_req_i.we && bus_req_i.addr == OFF_TRIM |=> fast_rc_trim_o == $past(bus_req_i.wdata[TRIM_W-1:0]); endproperty
	a_trim: assert property (p_trim) else $error("trim missed write");
	// Read data stand only in the cycle after a read, so a stale value never reaches software.
	property p_rd_idle; !$past(bus_req_i.re) |-> bus_rdata_o == 8'h00; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside read cycle");
	property p_boot_slow; $fell(srst_i) && cal_opt_i == CAL_SLOW |-> !fast_rc_osc_en_o && slow_rc_osc_en_o; endproperty
	a_boot_slow: assert property (p_boot_slow) else $error("slow option boot enables wrong");
endmodule
bind cssw_clock_switch cssw_clock_switch_checker #(.TRIM_W(TRIM_W)) u_chk (.sys_clk_i, .srst_i, .bus_req_i,
	.bus_rdata_o, .cal_opt_i, .core_clock_o, .fast_rc_osc_en_o, .slow_rc_osc_en_o, .ultra_slow_rc_osc_en_o,
	.fast_rc_trim_o, .wdt_en_o, .port_a_pin5_input_o, .calibrated_o);

// ---- dv/test_cssw_clock_switch.sv ----
// Self-checking bench of the core clock switch.
`timescale 1ns/1ps
// ====
// Bench
module test_cssw_clock_switch import cssw_pkg::*;;
	logic sys_clk_i = 1'b0;
	logic srst_i = 1'b1;
	cssw_bus_req_t req = '0;
	cssw_cal_t cal = CAL_OFF;
	logic bf = 1'b0;
	logic fo = 1'b0;
	logic so = 1'b0;
	logic [7:0] rdata;
	logic [7:0] trim;
	logic core, fen, sen, wdt, pin5, calb;
	logic rd_pend = 1'b0;
	logic [7:0] exp_q[$];
	logic [7:0] tab [7] = '{CLKMD_RST_SLOW_BOOT, CLKMD_RST_FAST_BOOT, CLKMD_FAST_DIV4, CLKMD_FAST_DIV8,
		CLKMD_FAST_DIV16, CLKMD_FAST_DIV32, CLKMD_SLOW};
	int n_errors = 0;
	int n_compared = 0;
	cssw_clock_switch u_dut (.sys_clk_i, .srst_i, .bus_req_i(req), .bus_rdata_o(rdata), .cal_opt_i(cal),
		.boot_fast_opt_i(bf), .fast_rc_osc_i(fo), .slow_rc_osc_i(so), .core_clock_o(core),
		.fast_rc_osc_en_o(fen), .slow_rc_osc_en_o(sen), .ultra_slow_rc_osc_en_o(), .fast_rc_trim_o(trim),
		.wdt_en_o(wdt), .port_a_pin5_input_o(pin5), .calibrated_o(calb));
	always #12.5 sys_clk_i = ~sys_clk_i;
	// A disabled oscillator stands still, so a wrong enable freezes the core clock.
	always #100 fo = fen ? ~fo : 1'b0;
	always #500 so = sen ? ~so : 1'b0;
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		req <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
		@(posedge sys_clk_i);
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		req <= '{addr: a, wdata: 8'h00, we: 1'b0, re: 1'b1};
		@(posedge sys_clk_i);
	endtask
	task automatic idle(input int n);
		req <= '0;
		repeat (n) @(posedge sys_clk_i);
	endtask
	// Two rises are skipped so that a fresh switch has settled before one period is counted.
	task automatic period(input int e);
		int n;
		int k;
		n = 0;
		req <= '0;
		for (k = 0; k < 3; k++) begin
			n = 0;
			while (core !== 1'b0 && n < 1200) begin
				@(posedge sys_clk_i);
				n++;
			end
			while (core !== 1'b1 && n < 1200) begin
				@(posedge sys_clk_i);
				n++;
			end
		end
		check(16'(n), 16'(e));
	endtask
	function automatic int exp_period(input logic [7:0] m);
		case (m[7:5])
			3'h7: return 40;
			3'h3: return 256;
			3'h1: return 64;
			3'h0: return m[3] ? 128 : 32;
			default: return 512;
		endcase
	endfunction
	task automatic end_of_test();
		$display("compared %0d errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	always @(posedge sys_clk_i) begin
		if (rd_pend) check(rdata, exp_q.pop_front());
		rd_pend <= req.re;
	end
	initial begin
		repeat (60000) @(posedge sys_clk_i);
		n_errors++;
		end_of_test();
	end
	initial begin
		logic [7:0] m;
		logic [7:0] t;
		logic [7:0] x;
		int i;
		void'($urandom(1470));
		for (i = 0; i < 7; i++) begin
			cal <= cssw_cal_t'(i < 2 ? 0 : i - 1);
			bf <= (i == 1);
			srst_i <= 1'b1;
			repeat (16) @(posedge sys_clk_i);
			srst_i <= 1'b0;
			@(posedge sys_clk_i);
			m = tab[i];
			rd(OFF_CLKMD, m);
			idle(1);
			check({wdt, calb, pin5, fen}, {i < 2, i >= 2, 1'b1, m[4]});
			period(exp_period(m));
		end
		// Software never drops the running oscillator in the switching write.
		wr(OFF_CLKMD, 8'hF4);
		wr(OFF_CLKMD, CLKMD_FAST_DIV8);
		rd(OFF_CLKMD, CLKMD_FAST_DIV8);
		period(64);
		wr(OFF_CLKMD, 8'h38);
		idle(2);
		check(sen, 1'b0);
		period(64);
		wr(OFF_CLKMD, CLKMD_FAST_DIV8);
		wr(OFF_CLKMD, CLKMD_FAST_DIV32);
		period(256);
		for (i = 2; i < 7; i++) begin
			m = (i == 6) ? 8'hF4 : tab[i];
			wr(OFF_CLKMD, m);
			rd(OFF_CLKMD, m);
			period(exp_period(m));
		end
		check(fen, 1'b1);
		wr(OFF_CLKMD, CLKMD_SLOW);
		period(40);
		rd(OFF_STATUS, 8'((1 << STAT_SLOW_BIT) | (1 << STAT_CAL_BIT)));
		wr(OFF_STATUS, 8'hFF);
		wr(OFF_CLKMD, 8'hF4);
		wr(OFF_CLKMD, CLKMD_FAST_DIV4);
		idle(1);
		rd(OFF_STATUS, 8'((1 << STAT_SLOW_BIT) | (1 << STAT_PENDING_BIT) | (1 << STAT_CAL_BIT)));
		period(32);
		repeat (4) begin
			t = 8'($urandom);
			x = 8'($urandom) & 8'h03;
			wr(OFF_TRIM, t);
			wr(OFF_MISC, x);
			rd(OFF_TRIM, t);
			rd(OFF_MISC, x);
			rd(4'($urandom_range(15, 4)), 8'h00);
			idle(2);
			check({trim, wdt, pin5}, {t, x[0], ~x[1]});
		end
		end_of_test();
	end
endmodule

// ---- logic/cssw_clock_switch.sv ----
// Core clock source select, divider and glitch-free switch with its register file.
//
// The implementer's own choices: the register offsets and strobed register access.
`timescale 1ns/1ps
module cssw_clock_switch
	import cssw_pkg::*;
#(
	parameter int TRIM_W = 8
) (
	input wire logic sys_clk_i,
	input wire logic srst_i,
	input wire cssw_bus_req_t bus_req_i,
	output logic [7:0] bus_rdata_o,
	input wire cssw_cal_t cal_opt_i,
	input wire logic boot_fast_opt_i,
	input wire logic fast_rc_osc_i,
	input wire logic slow_rc_osc_i,
	output logic core_clock_o,
	output logic fast_rc_osc_en_o,
	output logic slow_rc_osc_en_o,
	output logic ultra_slow_rc_osc_en_o,
	output logic [TRIM_W-1:0] fast_rc_trim_o,
	output logic wdt_en_o,
	output logic port_a_pin5_input_o,
	output logic calibrated_o
);
	// ==========================================================================
	// Elaboration checks
	// ==========================================================================
	if (TRIM_W < 1 || TRIM_W > 8) begin : g_bad_trim
		$error("TRIM_W must lie between 1 and 8.");
	end

	// ==========================================================================
	// Mode decode
	// ==========================================================================
	// Codes outside the documented set fall back to the slowest fast divider.
	function automatic cssw_sel_t decode_mode(input logic [7:0] m);
		cssw_sel_t s;
		s.slow = 1'b0;
		s.half = HALF_DIV64;
		case (m[CLKMD_MODE_LSB +: 3])
			MODE_SLOW: s.slow = 1'b1;
			MODE_DIV32: s.half = HALF_DIV32;
			MODE_DIV8: s.half = HALF_DIV8;
			MODE_DIV4_16: s.half = m[CLKMD_DIVSEL_BIT] ? HALF_DIV16 : HALF_DIV4;
			default: s.half = HALF_DIV64;
		endcase
		return s;
	endfunction

	function automatic logic [7:0] boot_mode(input cssw_cal_t c, input logic fast_opt);
		logic [7:0] m;
		m = CLKMD_RST_SLOW_BOOT;
		case (c)
			CAL_DIV4: m = CLKMD_FAST_DIV4;
			CAL_DIV8: m = CLKMD_FAST_DIV8;
			CAL_DIV16: m = CLKMD_FAST_DIV16;
			CAL_DIV32: m = CLKMD_FAST_DIV32;
			CAL_SLOW: m = CLKMD_SLOW;
			default: m = fast_opt ? CLKMD_RST_FAST_BOOT : CLKMD_RST_SLOW_BOOT;
		endcase
		return m;
	endfunction

	// ==========================================================================
	// Oscillator synchronisers
	// ==========================================================================
	// Oscillators are sampled by the system clock, so the fast one must stay
	// well below half the system rate; the divided output inherits that jitter.
	logic fast_lvl;
	logic fast_rise;
	logic slow_lvl;

	cssw_osc_sync u_fast_sync (
		.sys_clk_i(sys_clk_i),
		.srst_i(srst_i),
		.osc_i(fast_rc_osc_i),
		.level_o(fast_lvl),
		.rise_o(fast_rise)
	);

	cssw_osc_sync u_slow_sync (
		.sys_clk_i(sys_clk_i),
		.srst_i(srst_i),
		.osc_i(slow_rc_osc_i),
		.level_o(slow_lvl),
		.rise_o()
	);

	// ==========================================================================
	// State update
	// ==========================================================================
	cssw_core_t q, d;
	cssw_sel_t want;
	logic [7:0] boot_md;
	logic dead;
	logic src_lvl;

	assign boot_md = boot_mode(cal_opt_i, boot_fast_opt_i);

	always_comb begin
		d = q;
		d.rdata = 8'h00;
		want = decode_mode(q.clkmd);
		// A disabled active oscillator freezes the core clock; the block shows it.
		dead = q.cur.slow ? ~q.clkmd[CLKMD_SLOW_EN_BIT] : ~q.clkmd[CLKMD_FAST_EN_BIT];
		// Only the two oscillators can reach the core clock.
		src_lvl = q.cur.slow ? slow_lvl : q.div_clk;

		// Register writes.
		if (bus_req_i.we) begin
			case (bus_req_i.addr)
				OFF_CLKMD: d.clkmd = bus_req_i.wdata;
				OFF_TRIM: d.trim = bus_req_i.wdata;
				OFF_MISC: begin
					d.wdt_en = bus_req_i.wdata[MISC_WDT_EN_BIT];
					d.pin5_in = ~bus_req_i.wdata[MISC_PIN5_OUT_BIT];
				end
				default: d.rdata = 8'h00;
			endcase
		end

		// Register reads, answered in the following cycle only.
		if (bus_req_i.re) begin
			case (bus_req_i.addr)
				OFF_CLKMD: d.rdata = q.clkmd;
				OFF_TRIM: d.rdata = q.trim;
				OFF_STATUS: begin
					d.rdata[STAT_SLOW_BIT] = q.cur.slow;
					d.rdata[STAT_PENDING_BIT] = (q.fsm == ST_SWITCH);
					d.rdata[STAT_DEAD_BIT] = dead;
					d.rdata[STAT_CAL_BIT] = q.calibrated;
				end
				OFF_MISC: begin
					d.rdata[MISC_WDT_EN_BIT] = q.wdt_en;
					d.rdata[MISC_PIN5_OUT_BIT] = ~q.pin5_in;
				end
				default: d.rdata = 8'h00;
			endcase
		end

		// Fast divider: toggles after half of the selected ratio in fast edges.
		if (fast_rise) begin
			if (q.cnt >= q.cur.half) begin
				d.cnt = 5'h00;
				d.div_clk = ~q.div_clk;
			end else begin
				d.cnt = q.cnt + 5'h01;
			end
		end

		// Switch sequencer.
		case (q.fsm)
			ST_RUN: begin
				d.core = src_lvl;
				if (want != q.cur) begin
					d.fsm = ST_SWITCH;
				end
			end
			ST_SWITCH: begin
				// Follow the old source until it is low, then park low so the
				// old high phase is never cut short.
				d.core = q.core ? src_lvl : 1'b0;
				if (want == q.cur) begin
					d.fsm = ST_RUN;
				end else if (!q.core && (!want.slow || !slow_lvl)) begin
					// A new fast ratio starts from a fresh low half period.
					d.cur = want;
					d.cnt = 5'h00;
					d.div_clk = 1'b0;
					d.fsm = ST_RUN;
				end
			end
			default: begin
				d.fsm = ST_RUN;
				d.core = 1'b0;
			end
		endcase
	end

	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			q.fsm <= ST_RUN;
			q.clkmd <= boot_md;
			q.trim <= TRIM_RST;
			q.wdt_en <= (cal_opt_i == CAL_OFF);
			q.pin5_in <= 1'b1;
			q.calibrated <= (cal_opt_i != CAL_OFF);
			q.cur <= decode_mode(boot_md);
			q.cnt <= 5'h00;
			q.div_clk <= 1'b0;
			q.core <= 1'b0;
			q.rdata <= 8'h00;
		end else begin
			q <= d;
		end
	end

	// ==========================================================================
	// Outputs
	// ==========================================================================
	assign bus_rdata_o = q.rdata;
	assign core_clock_o = q.core;
	assign fast_rc_osc_en_o = q.clkmd[CLKMD_FAST_EN_BIT];
	assign slow_rc_osc_en_o = q.clkmd[CLKMD_SLOW_EN_BIT];
	assign ultra_slow_rc_osc_en_o = 1'b1;
	assign fast_rc_trim_o = q.trim[TRIM_W-1:0];
	assign wdt_en_o = q.wdt_en;
	assign port_a_pin5_input_o = q.pin5_in;
	assign calibrated_o = q.calibrated;

endmodule

// ---- logic/cssw_osc_sync.sv ----
// Two-stage synchroniser with rising-edge pulse for one oscillator input.
`timescale 1ns/1ps
module cssw_osc_sync (
	input wire logic sys_clk_i,
	input wire logic srst_i,
	input wire logic osc_i,
	output logic level_o,
	output logic rise_o
);
	// ==========================================================================
	// State
	// ==========================================================================
	typedef struct packed {
		logic [2:0] sh;
	} cssw_sync_t;

	cssw_sync_t q, d;

	// Stage zero is read only by stage one; all logic looks at later stages.
	always_comb begin
		d = q;
		d.sh = {q.sh[1:0], osc_i};
	end

	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign level_o = q.sh[1];
	assign rise_o = q.sh[1] & ~q.sh[2];

endmodule

// ---- logic/cssw_pkg.sv ----
// Shared constants, types and register map of the core clock select and switch block.
package cssw_pkg;

	// ==========================================================================
	// Register offsets on the plain register port
	// ==========================================================================
	localparam int ADDR_W = 4;
	localparam logic [3:0] OFF_CLKMD = 4'h0;
	localparam logic [3:0] OFF_TRIM = 4'h1;
	localparam logic [3:0] OFF_STATUS = 4'h2;
	localparam logic [3:0] OFF_MISC = 4'h3;

	// ==========================================================================
	// Clock mode register fields and codes
	// ==========================================================================
	localparam int CLKMD_SLOW_EN_BIT = 2;
	localparam int CLKMD_DIVSEL_BIT = 3;
	localparam int CLKMD_FAST_EN_BIT = 4;
	localparam int CLKMD_MODE_LSB = 5;
	localparam logic [2:0] MODE_SLOW = 3'h7;
	localparam logic [2:0] MODE_DIV32 = 3'h3;
	localparam logic [2:0] MODE_DIV8 = 3'h1;
	localparam logic [2:0] MODE_DIV4_16 = 3'h0;
	localparam logic [7:0] CLKMD_FAST_DIV4 = 8'h14;
	localparam logic [7:0] CLKMD_FAST_DIV8 = 8'h3C;
	localparam logic [7:0] CLKMD_FAST_DIV16 = 8'h1C;
	localparam logic [7:0] CLKMD_FAST_DIV32 = 8'h7C;
	localparam logic [7:0] CLKMD_SLOW = 8'hE4;
	localparam logic [7:0] CLKMD_RST_SLOW_BOOT = 8'hF4;
	localparam logic [7:0] CLKMD_RST_FAST_BOOT = 8'hD4;

	// Half period of the divided fast clock, in fast oscillator edges, minus one.
	localparam logic [4:0] HALF_DIV4 = 5'h01;
	localparam logic [4:0] HALF_DIV8 = 5'h03;
	localparam logic [4:0] HALF_DIV16 = 5'h07;
	localparam logic [4:0] HALF_DIV32 = 5'h0F;
	localparam logic [4:0] HALF_DIV64 = 5'h1F;

	// ==========================================================================
	// Trim, misc and status fields
	// ==========================================================================
	localparam logic [7:0] TRIM_RST = 8'h80;
	localparam int MISC_WDT_EN_BIT = 0;
	localparam int MISC_PIN5_OUT_BIT = 1;
	localparam int STAT_SLOW_BIT = 0;
	localparam int STAT_PENDING_BIT = 1;
	localparam int STAT_DEAD_BIT = 2;
	localparam int STAT_CAL_BIT = 3;

	// ==========================================================================
	// Types
	// ==========================================================================
	typedef enum logic [2:0] {
		CAL_OFF = 3'h0,
		CAL_DIV4 = 3'h1,
		CAL_DIV8 = 3'h2,
		CAL_DIV16 = 3'h3,
		CAL_DIV32 = 3'h4,
		CAL_SLOW = 3'h5
	} cssw_cal_t;

	typedef enum logic [1:0] {
		ST_RUN = 2'b01,
		ST_SWITCH = 2'b10
	} cssw_state_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [7:0] wdata;
		logic we;
		logic re;
	} cssw_bus_req_t;

	typedef struct packed {
		logic slow;
		logic [4:0] half;
	} cssw_sel_t;

	typedef struct packed {
		cssw_state_t fsm;
		logic [7:0] clkmd;
		logic [7:0] trim;
		logic wdt_en;
		logic pin5_in;
		logic calibrated;
		cssw_sel_t cur;
		logic [4:0] cnt;
		logic div_clk;
		logic core;
		logic [7:0] rdata;
	} cssw_core_t;

endpackage
